// ### hw/timer_channel.sv
// One 16-bit timer channel with waveform generation and an APB register port
// Functional notes
// - Clock source code 0-4 picks internal clocks, 5-7 the external clocks.
// - Count edge invert 0 counts rising edges, 1 counts falling edges.
// - Gate select 0 leaves clock ungated, 1-3 ANDs with external clock 0-2.
// - Stop-on-period-match stops the counter clock when count reaches period limit.
// - Disable-on-period-match disables the counter clock when count reaches period limit.
// - Event edge code: 0 none, 1 rising, 2 falling, 3 both edges.
// - Event source 0 takes line B as input; 1-3 take external clocks, B output.
// - Line B used as event input carries no waveform and no derived flags.
// - Without trigger enable an event only acts on lines A and B.
// - With trigger enable an event clears the counter and starts its clock if the clock is enabled.
// - Waveform shape picks up or up-down, with or without period trigger.
// - Waveform mode bit 1 means waveform generation, 0 means capture.
// - Line A actions for compare A, period, event, software trigger: none/set/clear/toggle.
// - Line B actions for compare B, period, event, software trigger: none/set/clear/toggle.
// - Counter readback returns the live count, upper bits zero.
// - Compare A and capture B registers writable only in waveform mode.
// - Period limit is read-write in both modes and reads back its value.
// - Overflow and all event flags stay set until a flags read clears them.
// - Overrun flags a capture register loaded twice unread; zero in waveform mode.
// - Compare A/B match flags set only in waveform mode on equality.
// - Load flags set on capture register loads, zero in waveform mode.
// - Period match and external trigger flags work in both modes.
// - Mirror bits show sampled pins in capture or for line B as event input, driven levels otherwise.
// - Software trigger resets counter, starts clock if enabled, applies trigger actions to lines in waveform mode.
`timescale 1ns/1ns
`default_nettype none

module timer_channel
  import timer_channel_pkg::*;
#(
  parameter int unsigned CNT_WIDTH = CNT_WIDTH_DEF
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [4:0] internal_clock,
  input wire logic [2:0] external_clock,
  input wire logic output_a_line_in,
  output logic output_a_line_out,
  output logic output_a_line_oe,
  input wire logic output_b_line_in,
  output logic output_b_line_out,
  output logic output_b_line_oe
);

  localparam logic [CNT_WIDTH-1:0] ALL_ONES = '1;
  localparam logic [CNT_WIDTH-1:0] ZERO = '0;

  // Apply one two-bit action to a line level
  function automatic logic line_act(input logic cur, input line_action_t act);
    case (act)
      ACT_SET: line_act = 1'b1;
      ACT_CLEAR: line_act = 1'b0;
      ACT_TOGGLE: line_act = ~cur;
      default: line_act = cur;
    endcase
  endfunction : line_act

  // Edge recognition on a sampled signal
  function automatic logic edge_hit(input logic prev, input logic cur, input logic [1:0] sel);
    case (sel)
      2'h1: edge_hit = ~prev & cur;
      2'h2: edge_hit = prev & ~cur;
      2'h3: edge_hit = prev ^ cur;
      default: edge_hit = 1'b0;
    endcase
  endfunction : edge_hit

  mode_t mode_reg;
  logic [CNT_WIDTH-1:0] count_reg, count_next;
  logic [CNT_WIDTH-1:0] compare_a_reg, compare_a_next;
  logic [CNT_WIDTH-1:0] capture_b_reg, capture_b_next;
  logic [CNT_WIDTH-1:0] period_reg;
  flags_t flags_reg, flags_next;
  flags_t flags_seen_reg;
  logic enabled_reg, enabled_next;
  logic stopped_reg, stopped_next;
  logic dir_up_reg, dir_up_next;
  logic clk_prev_reg, event_prev_reg, a_in_prev_reg;
  logic line_a_reg, line_a_next, line_b_reg, line_b_next;
  logic unread_a_reg, unread_b_reg;

  // Bus decode
  wire setup_phase = psel & ~penable;
  wire access = psel & penable;
  wire wr = access & pwrite;
  wire rd = access & ~pwrite;
  wire hit_ctrl = (paddr == CHANNEL_CONTROL_OFF);
  wire hit_mode = (paddr == WAVEFORM_CHANNEL_MODE_OFF);
  wire hit_cnt = (paddr == COUNTER_READBACK_OFF);
  wire hit_a = (paddr == COMPARE_A_VALUE_OFF);
  wire hit_b = (paddr == CAPTURE_B_VALUE_OFF);
  wire hit_per = (paddr == PERIOD_LIMIT_OFF);
  wire hit_flags = (paddr == CHANNEL_FLAGS_OFF);
  wire mapped = hit_ctrl | hit_mode | hit_cnt | hit_a | hit_b | hit_per | hit_flags;
  wire wave = mode_reg.waveform_mode;

  assign pready = 1'b1;
  assign pslverr = access & ~mapped;

  // Commands from the channel control register
  wire cmd_enable = wr & hit_ctrl & pwdata[CMD_CLOCK_ENABLE_BIT];
  wire cmd_disable = wr & hit_ctrl & pwdata[CMD_CLOCK_DISABLE_BIT];
  wire soft_trig = wr & hit_ctrl & pwdata[CMD_SOFT_TRIGGER_BIT];

  wire [7:0] clock_bus = {external_clock, internal_clock};
  wire sel_clock = clock_bus[mode_reg.clock_source_select];
  wire [3:0] gate_bus = {external_clock, 1'b1};
  wire gated_clock = sel_clock & gate_bus[mode_reg.gate_select];
  wire clk_edge = mode_reg.count_edge_invert ? (clk_prev_reg & ~gated_clock) : (~clk_prev_reg & gated_clock);
  wire running = enabled_reg & ~stopped_reg;
  wire tick = running & clk_edge;

  // event source and line B direction
  wire b_is_input = (mode_reg.ext_event_source == 2'h0);
  wire [3:0] event_bus = {external_clock, output_b_line_in};
  wire event_sig = event_bus[mode_reg.ext_event_source];
  wire ext_event = edge_hit(event_prev_reg, event_sig, mode_reg.ext_event_edge);
  // event acts as a trigger only when enabled
  wire ext_trig = ext_event & mode_reg.ext_event_trigger_enable;
  wire any_trig = ext_trig | soft_trig;

  wire period_trig_en = mode_reg.waveform_shape[1];
  wire up_down = mode_reg.waveform_shape[0];
  wire [CNT_WIDTH-1:0] top_val = period_trig_en ? period_reg : ALL_ONES;

  // Counting step
  logic [CNT_WIDTH-1:0] step_val;
  logic step_dir;
  always_comb begin
    step_val = count_reg;
    step_dir = dir_up_reg;
    if (up_down) begin
      // reverse at top and at zero
      if (dir_up_reg) begin
        if (count_reg >= top_val) begin
          step_dir = 1'b0;
          step_val = count_reg - 1'b1;
        end else begin
          step_val = count_reg + 1'b1;
        end
      end else begin
        if (count_reg == ZERO) begin
          step_dir = 1'b1;
          step_val = count_reg + 1'b1;
        end else begin
          step_val = count_reg - 1'b1;
        end
      end
    end else if (period_trig_en && count_reg == period_reg) begin
      step_val = ZERO;
    end else begin
      step_val = count_reg + 1'b1;
    end
  end

  wire wrap = tick & ~up_down & ~period_trig_en & (count_reg == ALL_ONES);
  wire period_hit = tick & (step_val == period_reg);
  wire match_a = tick & wave & (step_val == compare_a_reg);
  // no compare B activity while line B is an input
  wire match_b = tick & wave & ~b_is_input & (step_val == capture_b_reg);

  // Capture loads: A on rising line A, B on falling line A
  wire load_a = ~wave & ~a_in_prev_reg & output_a_line_in;
  wire load_b = ~wave & a_in_prev_reg & ~output_a_line_in;
  wire rd_a = rd & hit_a;
  wire rd_b = rd & hit_b;

  // Counter, direction and clock state
  always_comb begin
    count_next = count_reg;
    dir_up_next = dir_up_reg;
    enabled_next = enabled_reg;
    stopped_next = stopped_reg;
    if (tick) begin
      count_next = step_val;
      dir_up_next = step_dir;
    end
    if (period_hit && mode_reg.stop_on_c_match) begin
      stopped_next = 1'b1;
    end
    if (period_hit && mode_reg.disable_on_c_match) begin
      enabled_next = 1'b0;
    end
    if (cmd_enable && !cmd_disable) begin
      enabled_next = 1'b1;
    end
    if (cmd_disable) begin
      enabled_next = 1'b0;
    end
    // triggers reset counter and restart the clock if it is enabled
    if (any_trig) begin
      count_next = ZERO;
      dir_up_next = 1'b1;
      stopped_next = 1'b0;
    end
  end

  // Output line actions, lowest priority first
  always_comb begin
    line_a_next = line_a_reg;
    line_b_next = line_b_reg;
    if (wave) begin
      if (match_a) begin
        line_a_next = line_act(line_a_next, mode_reg.a_line_on_a_match);
      end
      if (period_hit) begin
        line_a_next = line_act(line_a_next, mode_reg.a_line_on_period_match);
      end
      if (ext_event) begin
        line_a_next = line_act(line_a_next, mode_reg.a_line_on_event);
      end
      if (soft_trig) begin
        line_a_next = line_act(line_a_next, mode_reg.a_line_on_soft_trigger);
      end
      if (match_b) begin
        line_b_next = line_act(line_b_next, mode_reg.b_line_on_b_match);
      end
      if (period_hit) begin
        line_b_next = line_act(line_b_next, mode_reg.b_line_on_period_match);
      end
      if (ext_event) begin
        line_b_next = line_act(line_b_next, mode_reg.b_line_on_event);
      end
      if (soft_trig) begin
        line_b_next = line_act(line_b_next, mode_reg.b_line_on_soft_trigger);
      end
    end
  end

  // value registers writable only in waveform mode
  always_comb begin
    compare_a_next = compare_a_reg;
    capture_b_next = capture_b_reg;
    if (wr && wave && hit_a) begin
      compare_a_next = pwdata[CNT_WIDTH-1:0];
    end
    if (wr && wave && hit_b) begin
      capture_b_next = pwdata[CNT_WIDTH-1:0];
    end
    if (load_a) begin
      compare_a_next = count_reg;
    end
    if (load_b) begin
      capture_b_next = count_reg;
    end
  end

  // Event flags; a set in the read cycle survives the clear
  flags_t flag_set;
  always_comb begin
    flag_set = '0;
    flag_set.overflow_flag = wrap;
    // second load before the register was read
    flag_set.overrun_flag = (load_a & unread_a_reg & ~rd_a) | (load_b & unread_b_reg & ~rd_b);
    // compare flags only in waveform mode
    flag_set.match_a_flag = match_a;
    flag_set.match_b_flag = match_b;
    // period match and trigger in both modes
    flag_set.period_match_flag = period_hit;
    flag_set.trigger_flag = ext_trig;
    flag_set.load_a_flag = load_a;
    flag_set.load_b_flag = load_b;
    // clear only the flags that were set when the read data was latched
    flags_next = ((rd && hit_flags) ? (flags_reg & ~flags_seen_reg) : flags_reg) | flag_set;
  end

  // Flags that depend on mode read as zero in the other mode
  flags_t flags_view;
  always_comb begin
    flags_view = flags_reg;
    flags_view.overrun_flag = flags_reg.overrun_flag & ~wave;
    flags_view.load_a_flag = flags_reg.load_a_flag & ~wave;
    flags_view.load_b_flag = flags_reg.load_b_flag & ~wave;
    flags_view.match_a_flag = flags_reg.match_a_flag & wave;
    flags_view.match_b_flag = flags_reg.match_b_flag & wave;
  end

  // mirror sampled pin or driven level
  wire mirror_a = wave ? line_a_reg : output_a_line_in;
  wire mirror_b = (wave && !b_is_input) ? line_b_reg : output_b_line_in;

  // Read data mux, latched in the setup phase so prdata comes from a flop
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0000_0000;
    if (hit_cnt) begin
      rd_mux[CNT_WIDTH-1:0] = count_reg;
    end
    if (hit_mode) begin
      rd_mux = mode_reg;
    end
    if (hit_a) begin
      rd_mux[CNT_WIDTH-1:0] = compare_a_reg;
    end
    if (hit_b) begin
      rd_mux[CNT_WIDTH-1:0] = capture_b_reg;
    end
    if (hit_per) begin
      rd_mux[CNT_WIDTH-1:0] = period_reg;
    end
    if (hit_flags) begin
      rd_mux[7:0] = flags_view;
      rd_mux[CLOCK_RUNNING_BIT] = enabled_reg;
      rd_mux[LINE_A_MIRROR_BIT] = mirror_a;
      rd_mux[LINE_B_MIRROR_BIT] = mirror_b;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_reg <= MODE_RESET;
      period_reg <= VALUE_RESET;
      prdata <= 32'h0000_0000;
      flags_seen_reg <= '0;
    end else begin
      if (wr && hit_mode) begin
        mode_reg <= pwdata;
      end
      if (wr && hit_per) begin
        period_reg <= pwdata[CNT_WIDTH-1:0];
      end
      if (setup_phase) begin
        prdata <= rd_mux;
        flags_seen_reg <= flags_reg;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_reg <= VALUE_RESET;
      compare_a_reg <= VALUE_RESET;
      capture_b_reg <= VALUE_RESET;
      flags_reg <= '0;
      enabled_reg <= 1'b0;
      stopped_reg <= 1'b0;
      dir_up_reg <= 1'b1;
    end else begin
      count_reg <= count_next;
      compare_a_reg <= compare_a_next;
      capture_b_reg <= capture_b_next;
      flags_reg <= flags_next;
      enabled_reg <= enabled_next;
      stopped_reg <= stopped_next;
      dir_up_reg <= dir_up_next;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clk_prev_reg <= 1'b0;
      event_prev_reg <= 1'b0;
      a_in_prev_reg <= 1'b0;
      line_a_reg <= 1'b0;
      line_b_reg <= 1'b0;
      unread_a_reg <= 1'b0;
      unread_b_reg <= 1'b0;
    end else begin
      clk_prev_reg <= gated_clock;
      event_prev_reg <= event_sig;
      a_in_prev_reg <= output_a_line_in;
      line_a_reg <= line_a_next;
      line_b_reg <= line_b_next;
      // A load marks the register unread; a read marks it seen
      unread_a_reg <= load_a | (unread_a_reg & ~rd_a);
      unread_b_reg <= load_b | (unread_b_reg & ~rd_b);
    end
  end

  // lines are driven only in waveform mode
  assign output_a_line_out = line_a_reg;
  assign output_a_line_oe = wave;
  // line B released while it is the event input
  assign output_b_line_out = line_b_reg;
  assign output_b_line_oe = wave & ~b_is_input;

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  a_flags_read_clear: assert property (
    (rd && hit_flags && flags_seen_reg.overflow_flag && !wrap) |=> !flags_reg.overflow_flag)
    else $error("overflow flag not cleared by a flags read");

  a_flag_set_wins: assert property (
    (rd && hit_flags && period_hit) |=> flags_reg.period_match_flag)
    else $error("period match lost in the clearing read");

  a_count_holds_stopped: assert property (
    (!running && !any_trig) |=> $stable(count_reg))
    else $error("counter moved while its clock was stopped");

  a_period_disable: assert property (
    (period_hit && mode_reg.disable_on_c_match && !cmd_enable) |=> !enabled_reg)
    else $error("clock still enabled after period match");

  a_soft_trig_reset: assert property (
    soft_trig |=> (count_reg == ZERO) && !stopped_reg)
    else $error("software trigger did not reset and start the counter");

  a_ro_capture_regs: assert property (
    (wr && hit_a && !wave && !load_a) |=> $stable(compare_a_reg))
    else $error("compare A written in capture mode");

  a_b_line_input: assert property (
    b_is_input |-> !output_b_line_oe ##1 (!flags_reg.match_b_flag || $past(flags_reg.match_b_flag)))
    else $error("line B driven while used as event input");

  a_wrap_overflow: assert property (
    (tick && !up_down && !period_trig_en && count_reg == ALL_ONES && !any_trig)
      |=> count_reg == ZERO && flags_reg.overflow_flag)
    else $error("wrap did not clear count and flag overflow");

  a_updown_turn: assert property (
    (tick && up_down && !dir_up_reg && count_reg == ZERO && !any_trig) |=> dir_up_reg && count_reg == 1)
    else $error("up-down counter did not turn at zero");

  a_ext_trigger: assert property (
    ext_trig |=> count_reg == ZERO ##0 flags_reg.trigger_flag)
    else $error("external trigger did not clear counter");

endmodule : timer_channel

`default_nettype wire

// ### hw/timer_channel_pkg.sv
// Register map, field layouts and reset values of the timer channel
package timer_channel_pkg;

  localparam int unsigned CNT_WIDTH_DEF = 16;

  // Byte offsets inside the channel window
  localparam logic [7:0] CHANNEL_CONTROL_OFF = 8'h00;
  localparam logic [7:0] WAVEFORM_CHANNEL_MODE_OFF = 8'h04;
  localparam logic [7:0] COUNTER_READBACK_OFF = 8'h10;
  localparam logic [7:0] COMPARE_A_VALUE_OFF = 8'h14;
  localparam logic [7:0] CAPTURE_B_VALUE_OFF = 8'h18;
  localparam logic [7:0] PERIOD_LIMIT_OFF = 8'h1c;
  localparam logic [7:0] CHANNEL_FLAGS_OFF = 8'h20;

  // Channel control command bits
  localparam int unsigned CMD_CLOCK_ENABLE_BIT = 0;
  localparam int unsigned CMD_CLOCK_DISABLE_BIT = 1;
  localparam int unsigned CMD_SOFT_TRIGGER_BIT = 2;

  // Status bit positions above the event flags
  localparam int unsigned CLOCK_RUNNING_BIT = 16;
  localparam int unsigned LINE_A_MIRROR_BIT = 17;
  localparam int unsigned LINE_B_MIRROR_BIT = 18;

  // Reset values
  localparam logic [31:0] MODE_RESET = 32'h0000_0000;
  localparam logic [15:0] VALUE_RESET = 16'h0000;

  // Action on an output line
  typedef enum logic [1:0] {
    ACT_NONE = 2'h0,
    ACT_SET = 2'h1,
    ACT_CLEAR = 2'h2,
    ACT_TOGGLE = 2'h3
  } line_action_t;

  // Waveform mode layout of waveform_channel_mode
  typedef struct packed {
    line_action_t b_line_on_soft_trigger;
    line_action_t b_line_on_event;
    line_action_t b_line_on_period_match;
    line_action_t b_line_on_b_match;
    line_action_t a_line_on_soft_trigger;
    line_action_t a_line_on_event;
    line_action_t a_line_on_period_match;
    line_action_t a_line_on_a_match;
    logic waveform_mode;
    logic [1:0] waveform_shape;
    logic ext_event_trigger_enable;
    logic [1:0] ext_event_source;
    logic [1:0] ext_event_edge;
    logic disable_on_c_match;
    logic stop_on_c_match;
    logic [1:0] gate_select;
    logic count_edge_invert;
    logic [2:0] clock_source_select;
  } mode_t;

  // Event flags in the low byte of channel_flags
  typedef struct packed {
    logic trigger_flag;
    logic load_b_flag;
    logic load_a_flag;
    logic period_match_flag;
    logic match_b_flag;
    logic match_a_flag;
    logic overrun_flag;
    logic overflow_flag;
  } flags_t;

endpackage : timer_channel_pkg

// ### bench/timer_far_side.sv
// Far-side model: internal and external clock sources and the two pin levels
`timescale 1ns/1ns
`default_nettype none

module timer_far_side (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [2:0] ext_run,
  input wire logic pin_a_level,
  input wire logic pin_b_level,
  input wire logic a_out,
  input wire logic a_oe,
  input wire logic b_out,
  input wire logic b_oe,
  output logic [4:0] internal_clock,
  output logic [2:0] external_clock,
  output logic a_in,
  output logic b_in
);
  logic [7:0] tick_cnt;

  // Every source stays slower than pclk/2, or edges would be lost in sampling
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_cnt <= 8'h00;
      internal_clock <= 5'h00;
      external_clock <= 3'h0;
    end else begin
      tick_cnt <= tick_cnt + 8'h01;
      for (int k = 0; k < 5; k++) begin
        if ((tick_cnt & ((8'h02 << k) - 8'h01)) == 8'h00) begin
          internal_clock[k] <= ~internal_clock[k];
        end
      end
      // A stopped external clock sits low
      external_clock <= ext_run & (external_clock ^ {3{(tick_cnt % 8'h06) == 8'h00}});
    end
  end

  // Pin level: the channel's drive wins while enabled
  assign a_in = a_oe ? a_out : pin_a_level;
  assign b_in = b_oe ? b_out : pin_b_level;
endmodule : timer_far_side
`default_nettype wire

// ### bench/test_timer_channel_waveform_status.sv
// Self-checking bench for the timer channel over APB
`timescale 1ns/1ns
`default_nettype none

module test_timer_channel_waveform_status
  import timer_channel_pkg::*;
;
  localparam logic [31:0] START = 32'h0000_0005;
  localparam logic [31:0] TRIG = 32'h0000_0004;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd, c0;
  logic [4:0] internal_clock;
  logic [2:0] external_clock, ext_run;
  logic a_out, a_oe, a_in, b_out, b_oe, b_in, pin_a, pin_b;
  mode_t md;
  int n_errors, tests_run;

  timer_channel i_timer_channel (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .internal_clock(internal_clock), .external_clock(external_clock), .output_a_line_in(a_in),
    .output_a_line_out(a_out), .output_a_line_oe(a_oe), .output_b_line_in(b_in),
    .output_b_line_out(b_out), .output_b_line_oe(b_oe));

  timer_far_side i_timer_far_side (.pclk(pclk), .presetn(presetn), .ext_run(ext_run),
    .pin_a_level(pin_a), .pin_b_level(pin_b), .a_out(a_out), .a_oe(a_oe), .b_out(b_out), .b_oe(b_oe),
    .internal_clock(internal_clock), .external_clock(external_clock), .a_in(a_in), .b_in(b_in));

  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask : check

  task automatic finish_test();
    $display("errors %0d, checks %0d", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : finish_test

  // One APB transfer; a fresh edge first so strobes never change twice in a step
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic err);
    int w;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    w = 0;
    do begin
      @(posedge pclk);
      w++;
    end while (pready !== 1'b1 && w < 50);
    if (w >= 50) begin
      n_errors++;
      finish_test();
    end
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic er;
    apb(1'b1, a, d, q, er);
  endtask : wr

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0, rd, e);
    check(rd, exp);
  endtask : rd_chk

  // Poll the live count, bounded
  task automatic wait_count(input logic [31:0] exp);
    int n;
    n = 0;
    do begin
      apb(1'b0, COUNTER_READBACK_OFF, 32'h0, rd, e);
      n++;
    end while (rd !== exp && n < 200);
    check(rd, exp);
  endtask : wait_count

  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    ext_run = 3'h0;
    pin_a = 1'b0;
    pin_b = 1'b0;
    n_errors = 0;
    tests_run = 0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    rd_chk(WAVEFORM_CHANNEL_MODE_OFF, MODE_RESET);
    rd_chk(CHANNEL_FLAGS_OFF, 32'h0);
    apb(1'b0, 8'h3c, 32'h0, rd, e);
    check({31'h0, e}, 32'h1);
    // Capture mode refuses compare writes
    wr(COMPARE_A_VALUE_OFF, 32'h0000_1234);
    rd_chk(COMPARE_A_VALUE_OFF, 32'h0);
    wr(PERIOD_LIMIT_OFF, 32'h0000_0003);
    rd_chk(PERIOD_LIMIT_OFF, 32'h3);
    // Every clock source, both edges, every gate, stop at the period
    ext_run <= 3'h7;
    for (int k = 0; k < 8; k++) begin
      md = '0;
      md.waveform_mode = 1'b1;
      md.waveform_shape = 2'b10;
      md.stop_on_c_match = 1'b1;
      md.clock_source_select = k[2:0];
      md.count_edge_invert = k[0];
      md.gate_select = k[1:0];
      wr(WAVEFORM_CHANNEL_MODE_OFF, md);
      wr(CHANNEL_CONTROL_OFF, START);
      wait_count(32'h3);
      check({31'h0, a_oe}, 32'h1);
    end
    ext_run <= 3'h0;
    md = '0;
    md.waveform_mode = 1'b1;
    md.waveform_shape = 2'b10;
    md.stop_on_c_match = 1'b1;
    md.ext_event_source = 2'h1;
    md.a_line_on_a_match = ACT_SET;
    md.b_line_on_b_match = ACT_SET;
    md.a_line_on_soft_trigger = ACT_CLEAR;
    md.b_line_on_soft_trigger = ACT_CLEAR;
    wr(WAVEFORM_CHANNEL_MODE_OFF, md);
    wr(PERIOD_LIMIT_OFF, 32'h0000_0005);
    wr(COMPARE_A_VALUE_OFF, 32'h0000_0002);
    wr(CAPTURE_B_VALUE_OFF, 32'h0000_0004);
    rd_chk(COMPARE_A_VALUE_OFF, 32'h2);
    apb(1'b0, CHANNEL_FLAGS_OFF, 32'h0, rd, e);
    wr(CHANNEL_CONTROL_OFF, START);
    wait_count(32'h5);
    rd_chk(CHANNEL_FLAGS_OFF, 32'h0007_001c);
    rd_chk(CHANNEL_FLAGS_OFF, 32'h0007_0000);
    check({30'h0, a_out, b_out}, 32'h3);
    check({31'h0, b_oe}, 32'h1);
    // Trigger toggles both lines; disable at period clears running state
    md.stop_on_c_match = 1'b0;
    md.disable_on_c_match = 1'b1;
    md.a_line_on_a_match = ACT_NONE;
    md.b_line_on_b_match = ACT_NONE;
    md.a_line_on_soft_trigger = ACT_TOGGLE;
    md.b_line_on_soft_trigger = ACT_TOGGLE;
    wr(WAVEFORM_CHANNEL_MODE_OFF, md);
    wr(CHANNEL_CONTROL_OFF, TRIG);
    wait_count(32'h5);
    rd_chk(CHANNEL_FLAGS_OFF, 32'h0000_001c);
    // Up-down with period trigger turns at the top instead of wrapping to zero
    md.disable_on_c_match = 1'b0;
    md.waveform_shape = 2'b11;
    wr(WAVEFORM_CHANNEL_MODE_OFF, md);
    wr(CHANNEL_CONTROL_OFF, START);
    wait_count(32'h5);
    repeat (2) apb(1'b0, COUNTER_READBACK_OFF, 32'h0, rd, e);
    check({31'h0, rd > 32'h2 && rd < 32'h5}, 32'h1);
    // External event with and without trigger enable
    for (int te = 0; te < 2; te++) begin
      md = '0;
      md.waveform_mode = 1'b1;
      md.ext_event_source = 2'h1;
      md.ext_event_edge = 2'h1;
      md.ext_event_trigger_enable = te[0];
      md.a_line_on_event = ACT_SET;
      md.a_line_on_soft_trigger = ACT_CLEAR;
      wr(WAVEFORM_CHANNEL_MODE_OFF, md);
      wr(CHANNEL_CONTROL_OFF, START);
      repeat (100) @(posedge pclk);
      apb(1'b0, COUNTER_READBACK_OFF, 32'h0, c0, e);
      check({31'h0, a_out}, 32'h0);
      ext_run <= 3'h1;
      repeat (10) @(posedge pclk);
      ext_run <= 3'h0;
      repeat (4) @(posedge pclk);
      apb(1'b0, COUNTER_READBACK_OFF, 32'h0, rd, e);
      check({31'h0, rd < c0}, {31'h0, te[0]});
      check({31'h0, a_out}, 32'h1);
    end
    md.ext_event_source = 2'h0;
    wr(WAVEFORM_CHANNEL_MODE_OFF, md);
    // The write lands on the edge that ends the task, so look half a cycle later
    @(negedge pclk);
    check({31'h0, b_oe}, 32'h0);
    wr(WAVEFORM_CHANNEL_MODE_OFF, 32'h0);
    @(negedge pclk);
    check({31'h0, a_oe}, 32'h0);
    // Capture: loads on line A edges, a second unread load is an overrun
    wr(CHANNEL_CONTROL_OFF, 32'h0000_0002);
    apb(1'b0, CHANNEL_FLAGS_OFF, 32'h0, rd, e);
    for (int p = 0; p < 3; p++) begin
      pin_a <= ~pin_a;
      repeat (3) @(posedge pclk);
    end
    rd_chk(CHANNEL_FLAGS_OFF, 32'h0002_0062);
    finish_test();
  end
endmodule : test_timer_channel_waveform_status
`default_nettype wire
